/* File: logic/tcsc_map.svh */
// register addresses, field positions, reset values and timing counts of the timer block
`ifndef TCSC_MAP_SVH
`define TCSC_MAP_SVH

`define TCSC_ADDR_CTRL       8'hc8
`define TCSC_ADDR_CLKSEL     8'hc9
`define TCSC_ADDR_RLD_LO     8'hca
`define TCSC_ADDR_RLD_HI     8'hcb
`define TCSC_ADDR_CNT_LO     8'hcc
`define TCSC_ADDR_CNT_HI     8'hcd
`define TCSC_BIT_BASE        8'hc8

`define TCSC_CTRL_HIGH_FLAG  7
`define TCSC_CTRL_LOW_FLAG   6
`define TCSC_CTRL_LOW_EN     5
`define TCSC_CTRL_SPLIT      4
`define TCSC_CTRL_UP_CAP     3
`define TCSC_CTRL_LO_CAP     2
`define TCSC_CTRL_UP_RUN     1
`define TCSC_CTRL_LO_RUN     0

`define TCSC_CLK_A_LO_LSB    0
`define TCSC_CLK_A_UP_LSB    2
`define TCSC_CLK_B_LO_LSB    4
`define TCSC_CLK_B_UP_LSB    6

`define TCSC_RST_CTRL        8'h00
`define TCSC_RST_CLKSEL      8'h00
`define TCSC_RST_BYTE        8'h00

`define TCSC_SYS_DIV         12

`endif

/* File: logic/tcsc_pkg.sv */
// types shared by the timer clock-select and control block
package tcsc_pkg;

	typedef enum logic [1:0] {
		TCSC_SRC_SYS    = 2'h0,
		TCSC_SRC_DIV12  = 2'h1,
		TCSC_SRC_RTC    = 2'h2,
		TCSC_SRC_PULSE  = 2'h3
	} tcsc_clksrc_t;

	typedef logic [7:0] tcsc_byte_t;

endpackage : tcsc_pkg

/* File: logic/tcsc_tick_sel.sv */
// counting-tick generation and per-half clock source selection
`timescale 1ns/1ps
`include "tcsc_map.svh"

module tcsc_tick_sel #(
	parameter int DIV = `TCSC_SYS_DIV
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rstn,
	// real-time sources, already on this clock
	input  wire logic             rtc_tick,
	input  wire logic             rtc_pulse,
	// four two-bit selection fields
	input  wire tcsc_pkg::tcsc_byte_t clksel,
	// one tick strobe per field
	output logic [3:0]            ticks
);
	import tcsc_pkg::*;

	localparam int DW = $clog2(DIV);

	// below two the prescaler cannot make a single-cycle strobe
	if (DIV < 2) begin : g_bad_div
		$error("divider must be at least 2");
	end

	logic [DW-1:0] div_cnt;
	logic [DW-1:0] next_div_cnt;
	logic          div_pulse;
	logic          next_div_pulse;

	// prescaler, free running so every half sees the same phase
	always_comb begin
		if (div_cnt == DW'(DIV - 1)) begin
			next_div_cnt   = '0;
			next_div_pulse = 1'b1;
		end else begin
			next_div_cnt   = div_cnt + DW'(1);
			next_div_pulse = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			div_cnt   <= '0;
			div_pulse <= 1'b0;
		end else begin
			div_cnt   <= next_div_cnt;
			div_pulse <= next_div_pulse;
		end
	end

	function automatic logic pick(input logic [1:0] field, input logic dp,
		input logic rt, input logic rp);
		case (tcsc_clksrc_t'(field))
			TCSC_SRC_SYS:   pick = 1'b1;
			TCSC_SRC_DIV12: pick = dp;
			TCSC_SRC_RTC:   pick = rt;
			TCSC_SRC_PULSE: pick = rp;
			default:        pick = 1'b0;
		endcase
	endfunction : pick

	// sys ticks on every cycle; the other sources are single-cycle strobes on the system clock
	for (genvar g = 0; g < 4; g++) begin : g_sel
		assign ticks[g] = pick(clksel[2*g +: 2], div_pulse, rtc_tick, rtc_pulse);
	end

endmodule : tcsc_tick_sel

/* File: logic/tcsc_timer.sv */
// first timer: control/status, clock select, counter, reload/capture and interrupt request
`timescale 1ns/1ps
`include "tcsc_map.svh"

// Overview of operation
// - two-bit field picks sys, div12, rtc, pulse tick
// - upper clock field only matters when split
// - lower clock field clocks lower or whole counter
// - second timer fields at bits 7:6, 5:4
// - high flag set on overflow or capture
// - low flag set by hardware, software clears
// - wide reload timer still flags low byte rollover
// - wide capture: capture sets high, overflow low
// - request is high OR low gated by enable
// - split bit selects one or two counters
// - upper capture enable only when split
// - lower capture enable covers whole counter wide
// - upper run only counts when split
// - lower run enables lower or whole counter
// - control at 0xc8, byte and bit writes
// - wide wrap without capture loads sixteen-bit reload, sets high
// - capture copies count even when stopped
// - split half wrap without capture reloads own byte, flags
// - capture source is external edge event
module tcsc_timer #(
	parameter int DIV = `TCSC_SYS_DIV
) (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 rstn,
	// special-function register port, byte access
	input  wire logic [7:0]           sfr_addr,
	input  wire tcsc_pkg::tcsc_byte_t sfr_wdata,
	input  wire logic                 sfr_wr,
	input  wire logic                 sfr_rd,
	output tcsc_pkg::tcsc_byte_t      sfr_rdata,
	// special-function register port, single-bit access
	input  wire logic [7:0]           sfr_bit_addr,
	input  wire logic                 sfr_bit_val,
	input  wire logic                 sfr_bit_wr,
	// event sources on this clock
	input  wire logic                 rtc_tick,
	input  wire logic                 rtc_pulse,
	input  wire logic                 external_edge_event_a,
	// interrupt request and second-timer ticks
	output logic                      timer_a_irq,
	output logic                      timer_b_upper_tick,
	output logic                      timer_b_lower_tick
);
	import tcsc_pkg::*;

	tcsc_byte_t timer_a_control_status;
	tcsc_byte_t timer_clock_source_select;
	tcsc_byte_t reload_capture_low_byte;
	tcsc_byte_t reload_capture_high_byte;
	tcsc_byte_t count_low_byte;
	tcsc_byte_t count_high_byte;
	tcsc_byte_t rdata_q;

	tcsc_byte_t next_ctrl;
	tcsc_byte_t next_clksel;
	tcsc_byte_t next_rld_lo;
	tcsc_byte_t next_rld_hi;
	tcsc_byte_t next_cnt_lo;
	tcsc_byte_t next_cnt_hi;
	tcsc_byte_t next_rdata;
	logic       next_irq;
	logic       irq_q;

	logic [3:0] ticks;

	logic split_select;
	logic upper_capture_enable;
	logic lower_capture_enable;
	logic upper_run;
	logic lower_run;

	assign split_select         = timer_a_control_status[`TCSC_CTRL_SPLIT];
	assign upper_capture_enable = timer_a_control_status[`TCSC_CTRL_UP_CAP];
	assign lower_capture_enable = timer_a_control_status[`TCSC_CTRL_LO_CAP];
	assign upper_run            = timer_a_control_status[`TCSC_CTRL_UP_RUN];
	assign lower_run            = timer_a_control_status[`TCSC_CTRL_LO_RUN];

	tcsc_tick_sel #(
		.DIV       (DIV)
	) u_tick (
		.clock     (clock),
		.rstn      (rstn),
		.rtc_tick  (rtc_tick),
		.rtc_pulse (rtc_pulse),
		.clksel    (timer_clock_source_select),
		.ticks     (ticks)
	);

	// second timer only needs its strobes, its counter lives elsewhere
	assign timer_b_lower_tick = ticks[`TCSC_CLK_B_LO_LSB/2];
	assign timer_b_upper_tick = ticks[`TCSC_CLK_B_UP_LSB/2];

	// bit access splits the address into block and index, so the block must align
	if ((`TCSC_BIT_BASE & 8'h07) != 8'h00) begin : g_bad_base
		$error("bit-addressable base must be a multiple of eight");
	end

	logic tick_lo;
	logic tick_up;
	assign tick_lo = ticks[`TCSC_CLK_A_LO_LSB/2];
	assign tick_up = ticks[`TCSC_CLK_A_UP_LSB/2];

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target,
		input logic strobe);
		hit = strobe && (addr == target);
	endfunction : hit

	// one eight-bit half: {wrapped, next count}
	function automatic logic [8:0] step8(input logic [7:0] cnt, input logic [7:0] rld,
		input logic step, input logic cap_mode);
		step8 = {1'b0, cnt};
		if (step) begin
			if (cnt == 8'hff) begin
				step8 = {1'b1, cap_mode ? 8'h00 : rld};
			end else begin
				step8 = {1'b0, cnt + 8'h01};
			end
		end
	endfunction : step8

	logic [8:0]  lo_res;
	logic [8:0]  up_res;
	logic [15:0] cnt16;
	logic        step_w;
	logic        step_lo;
	logic        step_up;
	logic        cap_w;
	logic        set_high;
	logic        set_low;
	logic        cap_lo;
	logic        cap_up;
	logic [7:0]  bit_mask;
	logic        ctrl_bit_wr;

	always_comb begin
		next_ctrl   = timer_a_control_status;
		next_clksel = timer_clock_source_select;
		next_rld_lo = reload_capture_low_byte;
		next_rld_hi = reload_capture_high_byte;
		next_cnt_lo = count_low_byte;
		next_cnt_hi = count_high_byte;
		next_rdata  = rdata_q;
		cnt16       = {count_high_byte, count_low_byte};
		set_high    = 1'b0;
		set_low     = 1'b0;
		cap_lo      = 1'b0;
		cap_up      = 1'b0;
		lo_res      = 9'h000;
		up_res      = 9'h000;
		step_w      = lower_run && tick_lo;
		step_lo     = lower_run && tick_lo;
		step_up     = upper_run && tick_up;
		cap_w       = lower_capture_enable;

		if (!split_select) begin
			// wide: lower controls govern the whole counter, upper ones ignored
			if (step_w) begin
				cnt16 = cnt16 + 16'h0001;
				if ({count_high_byte, count_low_byte} == 16'hffff) begin
					if (cap_w) begin
						set_low = 1'b1;
					end else begin
						cnt16    = {reload_capture_high_byte, reload_capture_low_byte};
						set_high = 1'b1;
					end
				end
				if (!cap_w && count_low_byte == 8'hff) begin
					set_low = 1'b1;
				end
			end
			next_cnt_lo = cnt16[7:0];
			next_cnt_hi = cnt16[15:8];

			// the pre-step count is copied, the value software last saw
			if (cap_w && external_edge_event_a) begin
				cap_lo   = 1'b1;
				cap_up   = 1'b1;
				set_high = 1'b1;
			end
		end else begin
			// split: halves are independent, sharing only the capture event
			lo_res      = step8(count_low_byte, reload_capture_low_byte, step_lo,
				lower_capture_enable);
			up_res      = step8(count_high_byte, reload_capture_high_byte, step_up,
				upper_capture_enable);
			next_cnt_lo = lo_res[7:0];
			next_cnt_hi = up_res[7:0];
			if (lo_res[8] && !lower_capture_enable) begin
				set_low = 1'b1;
			end
			if (up_res[8] && !upper_capture_enable) begin
				set_high = 1'b1;
			end

			if (external_edge_event_a) begin
				if (lower_capture_enable) begin
					cap_lo  = 1'b1;
					set_low = 1'b1;
				end
				if (upper_capture_enable) begin
					cap_up   = 1'b1;
					set_high = 1'b1;
				end
			end
		end

		// software byte and bit writes
		if (hit(sfr_addr, `TCSC_ADDR_CTRL, sfr_wr)) begin
			next_ctrl = sfr_wdata;
		end

		ctrl_bit_wr = sfr_bit_wr && (sfr_bit_addr[7:3] == 5'(`TCSC_BIT_BASE >> 3));
		bit_mask    = 8'h01 << sfr_bit_addr[2:0];
		if (ctrl_bit_wr) begin
			next_ctrl = sfr_bit_val ? (next_ctrl | bit_mask) : (next_ctrl & ~bit_mask);
		end

		if (hit(sfr_addr, `TCSC_ADDR_CLKSEL, sfr_wr)) begin
			next_clksel = sfr_wdata;
		end
		if (hit(sfr_addr, `TCSC_ADDR_RLD_LO, sfr_wr)) begin
			next_rld_lo = sfr_wdata;
		end
		if (hit(sfr_addr, `TCSC_ADDR_RLD_HI, sfr_wr)) begin
			next_rld_hi = sfr_wdata;
		end
		// count writes follow the step, so a software preset wins
		if (hit(sfr_addr, `TCSC_ADDR_CNT_LO, sfr_wr)) begin
			next_cnt_lo = sfr_wdata;
		end
		if (hit(sfr_addr, `TCSC_ADDR_CNT_HI, sfr_wr)) begin
			next_cnt_hi = sfr_wdata;
		end

		// a capture beats a software reload write in the same cycle
		if (cap_lo) begin
			next_rld_lo = count_low_byte;
		end
		if (cap_up) begin
			next_rld_hi = count_high_byte;
		end

		// hardware sets win over a software clear, and are never cleared here
		if (set_high) begin
			next_ctrl[`TCSC_CTRL_HIGH_FLAG] = 1'b1;
		end
		if (set_low) begin
			next_ctrl[`TCSC_CTRL_LOW_FLAG] = 1'b1;
		end

		// registered read data, unmapped addresses answer zero
		if (sfr_rd) begin
			case (sfr_addr)
				`TCSC_ADDR_CTRL:   next_rdata = timer_a_control_status;
				`TCSC_ADDR_CLKSEL: next_rdata = timer_clock_source_select;
				`TCSC_ADDR_RLD_LO: next_rdata = reload_capture_low_byte;
				`TCSC_ADDR_RLD_HI: next_rdata = reload_capture_high_byte;
				`TCSC_ADDR_CNT_LO: next_rdata = count_low_byte;
				`TCSC_ADDR_CNT_HI: next_rdata = count_high_byte;
				default:           next_rdata = 8'h00;
			endcase
		end

		next_irq = next_ctrl[`TCSC_CTRL_HIGH_FLAG] ||
			(next_ctrl[`TCSC_CTRL_LOW_FLAG] && next_ctrl[`TCSC_CTRL_LOW_EN]);
	end

	// one synchronous clear for the whole bank keeps flags and request aligned
	always_ff @(posedge clock) begin
		if (!rstn) begin
			timer_a_control_status    <= `TCSC_RST_CTRL;
			timer_clock_source_select <= `TCSC_RST_CLKSEL;
			reload_capture_low_byte   <= `TCSC_RST_BYTE;
			reload_capture_high_byte  <= `TCSC_RST_BYTE;
			count_low_byte            <= `TCSC_RST_BYTE;
			count_high_byte           <= `TCSC_RST_BYTE;
			rdata_q                   <= 8'h00;
			irq_q                     <= 1'b0;
		end else begin
			timer_a_control_status    <= next_ctrl;
			timer_clock_source_select <= next_clksel;
			reload_capture_low_byte   <= next_rld_lo;
			reload_capture_high_byte  <= next_rld_hi;
			count_low_byte            <= next_cnt_lo;
			count_high_byte           <= next_cnt_hi;
			rdata_q                   <= next_rdata;
			irq_q                     <= next_irq;
		end
	end

	assign sfr_rdata   = rdata_q;
	// irq_q tracks the flags in the same cycle they are stored
	assign timer_a_irq = irq_q;

endmodule : tcsc_timer

/* File: tb/tcsc_timer_properties.sv */
// port assertions for the first timer block
`timescale 1ns/1ps
module tcsc_chk #(
	parameter int DIV = 12
) (
	// clock and reset
	input wire logic	clock,
	input wire logic	rstn,
	// register port
	input wire logic [7:0]	sfr_addr,
	input wire tcsc_pkg::tcsc_byte_t	sfr_wdata,
	input wire logic	sfr_wr,
	input wire logic	sfr_rd,
	input wire tcsc_pkg::tcsc_byte_t	sfr_rdata,
	input wire logic	sfr_bit_wr,
	// events and outputs
	input wire logic	rtc_tick,
	input wire logic	rtc_pulse,
	input wire logic	timer_a_irq,
	input wire logic	timer_b_upper_tick,
	input wire logic	timer_b_lower_tick
);
	import tcsc_pkg::*;
	// the spacing sequence below is written for a divide by twelve
	if (DIV != 12) begin : g_div_fixed
		$error("spacing check needs a divider of twelve");
	end
	// clock select shadow, rebuilt from byte writes
	tcsc_byte_t	sel;
	tcsc_byte_t	next_sel;
	always_comb begin
		next_sel = sel;
		if (sfr_wr && sfr_addr == 8'hc9)
			next_sel = sfr_wdata;
	end
	always_ff @(posedge clock)
		sel <= rstn ? next_sel : 8'h00;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_rd(a);
		sfr_rd && sfr_addr == a;
	endsequence
	// divided tick: eleven quiet cycles between strobes
	sequence s_gap;
		!timer_b_lower_tick [*8] ##1 !timer_b_lower_tick [*3];
	endsequence
	property p_rst;
		disable iff (1'b0) !rstn |=> sfr_rdata == 8'h00 && !timer_a_irq;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset state wrong");
	property p_unmapped;
		sfr_rd && (sfr_addr < 8'hc8 || sfr_addr > 8'hcd) |=> sfr_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_sel_rd;
		s_rd(8'hc9) |=> sfr_rdata == $past(sel);
	endproperty
	a_sel_rd: assert property (p_sel_rd)
		else $error("clock select readback wrong");
	property p_irq;
		s_rd(8'hc8) |=> $past(timer_a_irq) == (sfr_rdata[7] | sfr_rdata[6] & sfr_rdata[5]);
	endproperty
	a_irq: assert property (p_irq)
		else $error("request not flag combination");
	// flags only drop by software writes
	property p_sticky;
		timer_a_irq && !sfr_wr && !sfr_bit_wr |=> timer_a_irq;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("request dropped without write");
	property p_b_lo_rtc;
		sel[5:4] == 2'h2 |-> timer_b_lower_tick == rtc_tick;
	endproperty
	a_b_lo_rtc: assert property (p_b_lo_rtc)
		else $error("lower tick not rtc");
	property p_b_up_pulse;
		sel[7:6] == 2'h3 |-> timer_b_upper_tick == rtc_pulse;
	endproperty
	a_b_up_pulse: assert property (p_b_up_pulse)
		else $error("upper tick not pulse");
	property p_div;
		timer_b_lower_tick && sel[5:4] == 2'h1 |=> s_gap ##1 timer_b_lower_tick;
	endproperty
	a_div: assert property (p_div)
		else $error("divided tick spacing wrong");
endmodule : tcsc_chk

bind tcsc_timer tcsc_chk #(
	.DIV                (DIV)
) chk_u (
	.clock              (clock),
	.rstn               (rstn),
	.sfr_addr           (sfr_addr),
	.sfr_wdata          (sfr_wdata),
	.sfr_wr             (sfr_wr),
	.sfr_rd             (sfr_rd),
	.sfr_rdata          (sfr_rdata),
	.sfr_bit_wr         (sfr_bit_wr),
	.rtc_tick           (rtc_tick),
	.rtc_pulse          (rtc_pulse),
	.timer_a_irq        (timer_a_irq),
	.timer_b_upper_tick (timer_b_upper_tick),
	.timer_b_lower_tick (timer_b_lower_tick)
);

/* File: tb/test_timer_clock_select_and_control.sv */
// self-checking bench for the first timer block
`timescale 1ns/1ps
module test_timer_clock_select_and_control;
	import tcsc_pkg::*;
	logic	clock = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
	logic	sfr_bit_val = 1'b0, sfr_bit_wr = 1'b0, rtc_tick = 1'b0;
	logic	rtc_pulse = 1'b0, external_edge_event_a = 1'b0;
	logic	timer_a_irq, timer_b_upper_tick, timer_b_lower_tick;
	logic [7:0]	sfr_addr = 8'h00, sfr_bit_addr = 8'h00;
	tcsc_byte_t	sfr_wdata = 8'h00, sfr_rdata;
	int	failures = 0, check_count = 0, cyc = 0, i;

	tcsc_timer dut_u (
		.clock                 (clock),
		.rstn                  (rstn),
		.sfr_addr              (sfr_addr),
		.sfr_wdata             (sfr_wdata),
		.sfr_wr                (sfr_wr),
		.sfr_rd                (sfr_rd),
		.sfr_rdata             (sfr_rdata),
		.sfr_bit_addr          (sfr_bit_addr),
		.sfr_bit_val           (sfr_bit_val),
		.sfr_bit_wr            (sfr_bit_wr),
		.rtc_tick              (rtc_tick),
		.rtc_pulse             (rtc_pulse),
		.external_edge_event_a (external_edge_event_a),
		.timer_a_irq           (timer_a_irq),
		.timer_b_upper_tick    (timer_b_upper_tick),
		.timer_b_lower_tick    (timer_b_lower_tick)
	);

	always #5 clock = ~clock;
	// hang guard, far above the longest wait
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [7:0] s, e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clock);
		#1 sfr_wr = 1'b0;
		// an idle edge keeps back-to-back strobes apart
		@(posedge clock);
		#1;
	endtask : wr
	task automatic bwr(input logic [7:0] a, input logic b);
		sfr_bit_addr = a;
		sfr_bit_val = b;
		sfr_bit_wr = 1'b1;
		@(posedge clock);
		#1 sfr_bit_wr = 1'b0;
		@(posedge clock);
		#1;
	endtask : bwr
	task automatic rc(input logic [7:0] a, e, input string n);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clock);
		#1 sfr_rd = 1'b0;
		chk(n, sfr_rdata, e);
		@(posedge clock);
		#1;
	endtask : rc
	task automatic wait_irq();
		for (i = 0; i < 400 && timer_a_irq !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
	endtask : wait_irq
	task automatic cap(input logic [7:0] c, e);
		wr(8'hc8, c);
		wr(8'hcc, 8'h56);
		wr(8'hcd, 8'h34);
		external_edge_event_a = 1'b1;
		@(posedge clock);
		#1 external_edge_event_a = 1'b0;
		rc(8'hc8, e, "ctrl");
	endtask : cap
	initial begin
		repeat (8) @(posedge clock);
		#1 rstn = 1'b1;
		rc(8'hc8, 8'h00, "ctrl");
		rc(8'hc9, 8'h00, "clksel");
		rc(8'hcf, 8'h00, "unmapped");
		// upper field on a silent source: wide mode must not care
		wr(8'hc9, 8'h0c);
		rc(8'hc9, 8'h0c, "clksel");
		$display("map test done");
		wr(8'hca, 8'h34);
		wr(8'hcb, 8'h12);
		wr(8'hcc, 8'hf0);
		wr(8'hcd, 8'hfe);
		wr(8'hc8, 8'h21);
		wait_irq();
		bwr(8'hc8, 1'b0);
		rc(8'hc8, 8'h60, "ctrl");
		rc(8'hcd, 8'hff, "count_hi");
		bwr(8'hce, 1'b0);
		chk("irq", 8'(timer_a_irq), 8'h00);
		bwr(8'hc8, 1'b1);
		wait_irq();
		bwr(8'hc8, 1'b0);
		rc(8'hc8, 8'he0, "ctrl");
		rc(8'hcd, 8'h12, "count_hi");
		bwr(8'hcf, 1'b0);
		chk("irq", 8'(timer_a_irq), 8'h01);
		bwr(8'hcd, 1'b0);
		chk("irq", 8'(timer_a_irq), 8'h00);
		$display("wide test done");
		wr(8'hc9, 8'hee);
		wr(8'hcb, 8'h77);
		wr(8'hcc, 8'h10);
		wr(8'hcd, 8'hfe);
		wr(8'hc8, 8'h13);
		// last pair of ticks lands with the upper half stopped
		for (i = 0; i < 4; i++) begin
			if (i == 3)
				bwr(8'hc9, 1'b0);
			rtc_tick = 1'b1;
			rtc_pulse = 1'b1;
			@(posedge clock);
			#1 rtc_tick = 1'b0;
			rtc_pulse = 1'b0;
			@(posedge clock);
			#1;
		end
		rc(8'hcc, 8'h14, "count_lo");
		rc(8'hcd, 8'h78, "count_hi");
		rc(8'hc8, 8'h91, "ctrl");
		$display("split test done");
		wr(8'hc9, 8'h10);
		cap(8'h04, 8'h84);
		rc(8'hca, 8'h56, "reload_lo");
		rc(8'hcb, 8'h34, "reload_hi");
		cap(8'h1c, 8'hdc);
		cap(8'h08, 8'h08);
		wr(8'hcc, 8'hff);
		wr(8'hcd, 8'hff);
		wr(8'hc8, 8'h05);
		bwr(8'hc8, 1'b0);
		rc(8'hc8, 8'h44, "ctrl");
		rc(8'hcd, 8'h00, "count_hi");
		// hold the divided tick for a full gap
		repeat (30) @(posedge clock);
		$display("capture test done");
		end_sim();
	end
endmodule : test_timer_clock_select_and_control
